//--- logic/evc_pkg.sv
`default_nettype none
package evc_pkg;
    // Register byte addresses on the 16-bit register port.
    localparam logic [15:0] EVC_ADDR_CLKSEL = 16'hFFB6;
    localparam logic [15:0] EVC_ADDR_COUNT  = 16'hFFB8;
    localparam logic [15:0] EVC_ADDR_CMP    = 16'hFFBA;
    localparam logic [15:0] EVC_ADDR_STATUS = 16'hFFBC;
    localparam logic [15:0] EVC_ADDR_EDGE   = 16'hFFBE;
    localparam logic [15:0] EVC_ADDR_IRQ    = 16'hFFC0;

    // Field positions in timer_ctrl_status.
    localparam int EVC_ST_OVF  = 7;
    localparam int EVC_ST_OVIE = 5;
    localparam int EVC_ST_CCLR = 4;
    // Field positions in clock_select_control.
    localparam int EVC_CS_HMSB = 6;
    localparam int EVC_CS_LMSB = 2;
    localparam int EVC_CS_LLSB = 0;
    // Field positions in the edge and interrupt control registers.
    localparam int EVC_EDGE_RISE = 0;
    localparam int EVC_IRQ_REQ   = 0;
    localparam int EVC_IRQ_EN    = 1;

    // Low-byte select codes below this value take the event pin.
    localparam logic [2:0]  EVC_LSEL_EXT_LIMIT = 3'h3;
    localparam logic [15:0] EVC_COUNT_MAX      = 16'hFFFF;
    localparam logic [7:0]  EVC_BYTE_MAX       = 8'hFF;

    // Reset values.
    localparam logic [15:0] EVC_RST_COUNT  = 16'h0000;
    localparam logic [15:0] EVC_RST_CMP    = 16'hFFFF;
    localparam logic [7:0]  EVC_RST_CLKSEL = 8'h00;
    localparam logic        EVC_RST_RISE   = 1'b1;
    localparam logic        EVC_RST_BIT    = 1'b0;

    // One register access from the software port.
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } evc_req_t;
endpackage : evc_pkg
`default_nettype wire

//--- logic/evc_top.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module evc_top (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire evc_pkg::evc_req_t bus_req,
    input  wire logic              event_input_pin,
    output var  logic [15:0]       rdata_r,
    output var  logic              irq_cpu_r
);
    import evc_pkg::*;

    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [15:0] cmp_r;
    logic [7:0]  clksel_r;
    logic        high_overflow_flag_r;
    logic        ovie_r;
    logic        cclr_r;
    logic        armed_r;
    logic        rise_r;
    logic        req_r;
    logic        ien_r;
    logic        ev_s1_r;
    logic        ev_s2_r;
    logic        ev_s3_r;
    logic        ovf_evt;
    logic        inc;
    logic        mode16;
    logic        cmp_clr;
    logic        wr_count;
    logic        wr_status;

    // Selects a write strobe for one register address.
    function automatic logic hit(input evc_req_t r, input logic [15:0] a);
        return r.wr && (r.addr == a);
    endfunction : hit

    assign wr_count  = hit(bus_req, EVC_ADDR_COUNT);
    assign wr_status = hit(bus_req, EVC_ADDR_STATUS);
    assign mode16    = ~clksel_r[EVC_CS_HMSB];

    ////////////////////////////////////////////////////////////////////////////
    // Event pin synchroniser; only the second and third stages are compared.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ev_s1_r <= 1'b0;
            ev_s2_r <= 1'b0;
            ev_s3_r <= 1'b0;
        end else begin
            ev_s1_r <= event_input_pin;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end

    // Qualified edge, counted only while the low byte takes the event pin.
    assign inc = (clksel_r[EVC_CS_LMSB:EVC_CS_LLSB] < EVC_LSEL_EXT_LIMIT) &&
                 (rise_r ? (ev_s2_r && !ev_s3_r) : (!ev_s2_r && ev_s3_r));

    ////////////////////////////////////////////////////////////////////////////
    // Counter next value. A software write wins over counting, so a loaded
    // value is never disturbed by an edge in the same cycle.
    assign cmp_clr = mode16 && cclr_r && (count_r == cmp_r);
    always_comb begin
        count_nxt = count_r;
        ovf_evt   = 1'b0;
        if (wr_count) begin
            count_nxt = bus_req.wdata;
        end else if (cmp_clr) begin
            count_nxt = EVC_RST_COUNT;
        end else if (inc && mode16) begin
            count_nxt = count_r + 16'h0001;
            ovf_evt   = (count_r == EVC_COUNT_MAX);
        end else if (inc) begin
            // Split mode: the upper byte has no internal prescaler here.
            count_nxt = {count_r[15:8], 8'(count_r[7:0] + 8'h01)};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count_r <= EVC_RST_COUNT;
        end else begin
            count_r <= count_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Plain configuration registers.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmp_r    <= EVC_RST_CMP;
            clksel_r <= EVC_RST_CLKSEL;
            rise_r   <= EVC_RST_RISE;
            ovie_r   <= EVC_RST_BIT;
            cclr_r   <= EVC_RST_BIT;
            ien_r    <= EVC_RST_BIT;
        end else begin
            if (hit(bus_req, EVC_ADDR_CMP)) begin
                cmp_r <= bus_req.wdata;
            end
            if (hit(bus_req, EVC_ADDR_CLKSEL)) begin
                clksel_r <= bus_req.wdata[7:0];
            end
            if (hit(bus_req, EVC_ADDR_EDGE)) begin
                rise_r <= bus_req.wdata[EVC_EDGE_RISE];
            end
            if (wr_status) begin
                ovie_r <= bus_req.wdata[EVC_ST_OVIE];
                cclr_r <= bus_req.wdata[EVC_ST_CCLR];
            end
            if (hit(bus_req, EVC_ADDR_IRQ)) begin
                ien_r <= bus_req.wdata[EVC_IRQ_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag. A read that sees it at 1 arms the clear; the next status
    // write clears it if its bit 7 is 0. A new overflow always wins the cycle.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            high_overflow_flag_r  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            if (ovf_evt) begin
                high_overflow_flag_r <= 1'b1;
            end else if (wr_status && armed_r && !bus_req.wdata[EVC_ST_OVF]) begin
                high_overflow_flag_r <= 1'b0;
            end
            if (bus_req.rd && bus_req.addr == EVC_ADDR_STATUS && high_overflow_flag_r) begin
                armed_r <= 1'b1;
            end else if (wr_status) begin
                armed_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request flag and forwarding to the CPU; software clears it by writing 0.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_r     <= 1'b0;
            irq_cpu_r <= 1'b0;
        end else begin
            if (ovf_evt && ovie_r) begin
                req_r <= 1'b1;
            end else if (hit(bus_req, EVC_ADDR_IRQ) && !bus_req.wdata[EVC_IRQ_REQ]) begin
                req_r <= 1'b0;
            end
            irq_cpu_r <= req_r && ien_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the read strobe; unmapped reads zero.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 16'h0000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                EVC_ADDR_COUNT:  rdata_r <= count_r;
                EVC_ADDR_CMP:    rdata_r <= cmp_r;
                EVC_ADDR_CLKSEL: rdata_r <= {8'h00, clksel_r};
                EVC_ADDR_STATUS: rdata_r <= {8'h00, high_overflow_flag_r, 1'b0, ovie_r, cclr_r, 4'h0};
                EVC_ADDR_EDGE:   rdata_r <= {15'h0000, rise_r};
                EVC_ADDR_IRQ:    rdata_r <= {14'h0000, ien_r, req_r};
                default:         rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    ovf_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        ovf_evt |=> high_overflow_flag_r)
        else $error("overflow did not set flag");
    flag_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(high_overflow_flag_r) |-> $past(armed_r && wr_status && !bus_req.wdata[EVC_ST_OVF]))
        else $error("overflow flag cleared without read-then-write-0");
    irq_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
        (ovf_evt && !ovie_r && !req_r) |=> !req_r)
        else $error("request raised with interrupt disabled");
    cmp_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
        (cmp_clr && !wr_count) |=> count_r == 16'h0000)
        else $error("compare match did not clear");
    mode_split_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!mode16 && !wr_count) |=> count_r[15:8] == $past(count_r[15:8]))
        else $error("upper byte moved in split mode");
    full_rollover_a: assert property (@(posedge mclk) disable iff (!nrst)
        (mode16 && inc && !wr_count && !cmp_clr && count_r == EVC_COUNT_MAX)
        |=> (count_r == 16'h0000) && high_overflow_flag_r) else $error("rollover wrong");
    // The forwarded level follows the enable as it stood one cycle before.
    irq_fwd_a: assert property (@(posedge mclk) disable iff (!nrst)
        (ovf_evt && ovie_r) |=> req_r ##1 (irq_cpu_r == $past(ien_r)))
        else $error("request not forwarded");
    edge_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!wr_count && !cmp_clr && (ev_s2_r == ev_s3_r)) |=> count_r == $past(count_r))
        else $error("counter moved without a qualified edge");
    count_inc_a: assert property (@(posedge mclk) disable iff (!nrst)
        (inc && mode16 && !wr_count && !cmp_clr)
        |=> count_r == 16'($past(count_r) + 16'h0001))
        else $error("count did not advance by one");

    // Main scenarios: enabled overflow, flag clear, compare clear, split-mode count.
    rollover_c: cover property (@(posedge mclk) disable iff (!nrst) ovf_evt && ovie_r);
    clear_c:    cover property (@(posedge mclk) disable iff (!nrst) $fell(high_overflow_flag_r));
    cmp_c:      cover property (@(posedge mclk) disable iff (!nrst) cmp_clr && !wr_count);
    split_c:    cover property (@(posedge mclk) disable iff (!nrst) !mode16 && inc);
endmodule : evc_top
`default_nettype wire

//--- tb/evc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// Event source for the counter pin; it idles low between pulses.
module evc_pulse_src (
    input  wire logic mclk,
    output var  logic pin
);
    initial pin = 1'b0;
    // Each level holds three clocks, because a shorter level could slip past the sampler.
    task automatic level(input logic v);
        pin <= v;
        repeat (3) @(posedge mclk);
    endtask : level
    // Whole pulses only, so the pin always ends low.
    task automatic pulse(input int k);
        repeat (k) begin
            level(1'b1);
            level(1'b0);
        end
    endtask : pulse
endmodule : evc_pulse_src
`default_nettype wire

//--- tb/tb_event_counter_16bit_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_event_counter_16bit_status;
    import evc_pkg::*;
    logic        mclk;
    logic        nrst;
    logic        pin;
    logic [15:0] rdata_r;
    logic        irq_cpu_r;
    evc_req_t    req;
    int          errors = 0;
    int          tests_run = 0;
    int          seed = 14631;
    int          m_cnt;
    int          n;

    evc_top evc_top_i (.mclk(mclk), .nrst(nrst), .bus_req(req), .event_input_pin(pin),
                       .rdata_r(rdata_r), .irq_cpu_r(irq_cpu_r));
    evc_pulse_src evc_pulse_src_i (.mclk(mclk), .pin(pin));

    ////////////////////////////////////////////////////////////////////////////////
    // Ends the run with the verdict.
    task automatic final_report();
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // Compares one result and counts it.
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One-cycle write strobe.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd_chk(input string nm, input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 chk(nm, e, rdata_r);
    endtask : rd_chk
    // Pulses the pin and advances the reference count.
    task automatic pulses(input int k);
        evc_pulse_src_i.pulse(k);
        m_cnt = (m_cnt + k) & 16'hFFFF;
        repeat (2) @(posedge mclk);
    endtask : pulses

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #(25 * 20000);
        errors++;
        final_report();
    end

    // Main sequence.
    initial begin
        nrst = 1'b0;
        req  = '0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk("count", EVC_ADDR_COUNT, EVC_RST_COUNT);
        rd_chk("compare", EVC_ADDR_CMP, EVC_RST_CMP);
        rd_chk("status", EVC_ADDR_STATUS, 16'h0000);
        rd_chk("unmapped", 16'hFFB0, 16'h0000);
        // Read data fall back to zero in the cycle after they stood.
        @(posedge mclk);
        #1 chk("rdata_idle", 16'h0000, rdata_r);
        rd_chk("clksel", EVC_ADDR_CLKSEL, 16'h0000);
        rd_chk("edge", EVC_ADDR_EDGE, 16'h0001);
        rd_chk("irq_reg", EVC_ADDR_IRQ, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            m_cnt = $random(seed) & 16'h0FFF;
            n = ($random(seed) & 7) + 1;
            wr(EVC_ADDR_COUNT, m_cnt[15:0]);
            pulses(n);
            rd_chk("count", EVC_ADDR_COUNT, m_cnt[15:0]);
        end
        // Overflow with the interrupt path open, then the read-before-clear sequence.
        wr(EVC_ADDR_IRQ, 16'h0002);
        wr(EVC_ADDR_STATUS, 16'h0020);
        wr(EVC_ADDR_COUNT, 16'hFFFE);
        pulses(2);
        rd_chk("count", EVC_ADDR_COUNT, 16'h0000);
        chk("irq_cpu", 16'h0001, {15'h0000, irq_cpu_r});
        wr(EVC_ADDR_STATUS, 16'h0020);
        rd_chk("status", EVC_ADDR_STATUS, 16'h00A0);
        // Armed now: writing 1 must leave the flag set, the next read re-arms it.
        wr(EVC_ADDR_STATUS, 16'h00A0);
        rd_chk("status", EVC_ADDR_STATUS, 16'h00A0);
        wr(EVC_ADDR_STATUS, 16'h0020);
        rd_chk("status", EVC_ADDR_STATUS, 16'h0020);
        wr(EVC_ADDR_IRQ, 16'h0002);
        repeat (2) @(posedge mclk);
        #1 chk("irq_cpu", 16'h0000, {15'h0000, irq_cpu_r});
        // Overflow with the enable off sets only the flag.
        wr(EVC_ADDR_STATUS, 16'h0000);
        wr(EVC_ADDR_COUNT, 16'hFFFF);
        pulses(1);
        #1 chk("irq_cpu", 16'h0000, {15'h0000, irq_cpu_r});
        rd_chk("status", EVC_ADDR_STATUS, 16'h0080);
        rd_chk("irq_reg", EVC_ADDR_IRQ, 16'h0002);
        // Compare clear on and off.
        wr(EVC_ADDR_CMP, 16'h0005);
        wr(EVC_ADDR_COUNT, 16'h0003);
        wr(EVC_ADDR_STATUS, 16'h0010);
        pulses(2);
        rd_chk("count", EVC_ADDR_COUNT, 16'h0000);
        wr(EVC_ADDR_STATUS, 16'h0000);
        wr(EVC_ADDR_COUNT, 16'h0003);
        pulses(2);
        rd_chk("count", EVC_ADDR_COUNT, 16'h0005);
        // Split mode: the low byte wraps without carry or flag.
        wr(EVC_ADDR_CLKSEL, 16'h0040);
        wr(EVC_ADDR_COUNT, 16'h12FF);
        pulses(1);
        rd_chk("count", EVC_ADDR_COUNT, 16'h1200);
        rd_chk("status", EVC_ADDR_STATUS, 16'h0000);
        // A select code of three takes no pin edges.
        wr(EVC_ADDR_CLKSEL, 16'h0003);
        wr(EVC_ADDR_COUNT, 16'h0040);
        pulses(1);
        rd_chk("count", EVC_ADDR_COUNT, 16'h0040);
        // Falling-edge counting.
        wr(EVC_ADDR_CLKSEL, 16'h0000);
        wr(EVC_ADDR_EDGE, 16'h0000);
        wr(EVC_ADDR_COUNT, 16'h0100);
        evc_pulse_src_i.level(1'b1);
        rd_chk("count", EVC_ADDR_COUNT, 16'h0100);
        @(posedge mclk);
        evc_pulse_src_i.level(1'b0);
        repeat (2) @(posedge mclk);
        rd_chk("count", EVC_ADDR_COUNT, 16'h0101);
        final_report();
    end
endmodule : tb_event_counter_16bit_status
`default_nettype wire
